// ===== src/eiwv_top.sv
// eiwv_top: external interrupt pin, wake-up from sleep and vectoring to the
// fixed interrupt address. assumes the core reports sleep entry, retired
// instructions and the next pc, and obeys pc load and stack push pulses.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module eiwv_top (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // register port
  input  wire eiwv_pkg::eiwv_bus_s      busIn,
  output logic [eiwv_pkg::DATA_W-1:0]   rdData,
  // external pin
  input  wire logic                    extIrqPin,
  // processor core
  input  wire eiwv_pkg::eiwv_core_in_s  coreIn,
  output eiwv_pkg::eiwv_core_out_s      coreOut,
  output logic                         sleeping,
  // interrupt
  output logic                         irqOut
);
  import eiwv_pkg::*;

  // register state
  logic                globalIrqEnable_r;
  logic                extIrqEnable_r;
  logic                extIrqFlag_r;
  logic [DATA_W-1:0]   timerEdgeConfig_r;
  logic [DATA_W-1:0]   rdData_r;

  // sequencer state
  eiwv_seq_e           seq_r;
  eiwv_seq_e           seq_nxt;
  logic                enableAtSleep_r;
  eiwv_core_out_s      coreOut_r;
  logic                sleeping_r;

  // internal events
  logic                edgePulse;
  logic                vectorNow;
  logic                wakeNow;
  logic [EVT_N-1:0]    evtIn;
  logic [EVT_N-1:0]    evtStatus;
  logic [EVT_N-1:0]    evtMask;

  // register decodes
  logic                wrControl;
  logic                wrTimerEdge;
  logic                wrStatus;
  logic                wrMask;

  // address match on the register port
  function automatic logic hit(input eiwv_bus_s b, input logic [ADDR_W-1:0] ofs);
    hit = b.addr == ofs;
  endfunction : hit

  function automatic logic vectorReady(input logic flag, input logic extIe, input logic globalIe);
    vectorReady = flag && extIe && globalIe;
  endfunction : vectorReady

  // irq_control_reg as software reads it
  function automatic logic [DATA_W-1:0] controlView(input logic globalIe, input logic extIe, input logic flag);
    controlView                = '0;
    controlView[BIT_GLOBAL_IE] = globalIe;
    controlView[BIT_EXT_IE]    = extIe;
    controlView[BIT_EXT_FLAG]  = flag;
  endfunction : controlView

  assign wrControl   = busIn.wr && hit(busIn, OFS_IRQ_CONTROL);
  assign wrTimerEdge = busIn.wr && hit(busIn, OFS_TIMER_EDGE);
  assign wrStatus    = busIn.wr && hit(busIn, OFS_EVT_STATUS);
  assign wrMask      = busIn.wr && hit(busIn, OFS_EVT_MASK);

  // pin edge capture
  // polarity bit picks edge
  eiwv_edge_catch u_edge (
    .core_clk           (core_clk),
    .rst                (rst),
    .extIrqPin          (extIrqPin),
    .edgePolaritySelect (timerEdgeConfig_r[BIT_EDGE_POL]),
    .edgePulse          (edgePulse)
  );

  // timer_edge_config, other bits kept for the timer
  // polarity change while pin differs fakes an edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timerEdgeConfig_r <= TIMER_EDGE_RST;
    end else if (wrTimerEdge) begin
      timerEdgeConfig_r <= busIn.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extIrqFlag_r <= 1'b0;
    end else if (edgePulse) begin
      extIrqFlag_r <= 1'b1;
    end else if (wrControl) begin
      extIrqFlag_r <= busIn.wdata[BIT_EXT_FLAG];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extIrqEnable_r <= IRQ_CONTROL_RST[BIT_EXT_IE];
    end else if (wrControl) begin
      extIrqEnable_r <= busIn.wdata[BIT_EXT_IE];
    end
  end

  // global enable: dropped on vectoring, restored on return
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      globalIrqEnable_r <= IRQ_CONTROL_RST[BIT_GLOBAL_IE];
    end else if (vectorNow) begin
      globalIrqEnable_r <= 1'b0;
    end else if (wrControl) begin
      globalIrqEnable_r <= busIn.wdata[BIT_GLOBAL_IE];
    end else if (coreIn.retFromIrq) begin
      globalIrqEnable_r <= 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= '0;
    end else if (busIn.rd) begin
      unique case (busIn.addr)
        OFS_IRQ_CONTROL: begin
          rdData_r <= controlView(globalIrqEnable_r, extIrqEnable_r, extIrqFlag_r);
        end
        OFS_TIMER_EDGE: begin
          rdData_r <= timerEdgeConfig_r;
        end
        OFS_EVT_STATUS: begin
          rdData_r <= {{(DATA_W-EVT_N){1'b0}}, evtStatus};
        end
        OFS_EVT_MASK: begin
          rdData_r <= {{(DATA_W-EVT_N){1'b0}}, evtMask};
        end
        default: begin
          rdData_r <= '0;
        end
      endcase
    end else begin
      rdData_r <= '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableAtSleep_r <= 1'b0;
    end else if (seq_r == SEQ_RUN && coreIn.sleepExec) begin
      enableAtSleep_r <= extIrqEnable_r;
    end
  end

  assign wakeNow = seq_r == SEQ_SLEEP && extIrqFlag_r && enableAtSleep_r;

  always_comb begin
    vectorNow = 1'b0;
    unique case (seq_r)
      SEQ_RUN: begin
        vectorNow = coreIn.instrDone && vectorReady(extIrqFlag_r, extIrqEnable_r, globalIrqEnable_r);
      end
      SEQ_WAKE_STEP: begin
        vectorNow = coreIn.instrDone && vectorReady(extIrqFlag_r, extIrqEnable_r, globalIrqEnable_r);
      end
      SEQ_SLEEP: begin
        vectorNow = 1'b0;
      end
      default: begin
        vectorNow = 1'b0;
      end
    endcase
  end

  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      SEQ_RUN: begin
        if (coreIn.sleepExec && !vectorNow) begin
          seq_nxt = SEQ_SLEEP;
        end
      end
      SEQ_SLEEP: begin
        if (wakeNow) begin
          seq_nxt = globalIrqEnable_r ? SEQ_WAKE_STEP : SEQ_RUN;
        end
      end
      SEQ_WAKE_STEP: begin
        if (coreIn.instrDone) begin
          seq_nxt = SEQ_RUN;
        end
      end
      // unused code falls back to run
      default: begin
        seq_nxt = SEQ_RUN;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_r <= SEQ_RUN;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // sleeping shown from the next state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleeping_r <= 1'b0;
    end else begin
      sleeping_r <= seq_nxt == SEQ_SLEEP;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreOut_r.wake <= 1'b0;
    end else begin
      coreOut_r.wake <= wakeNow;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreOut_r.pcLoad    <= 1'b0;
      coreOut_r.pcLoadVal <= IRQ_VECTOR;
      coreOut_r.stackPush <= 1'b0;
      coreOut_r.stackData <= '0;
    end else begin
      coreOut_r.pcLoad    <= vectorNow;
      coreOut_r.pcLoadVal <= IRQ_VECTOR;
      coreOut_r.stackPush <= vectorNow;
      if (vectorNow) begin
        coreOut_r.stackData <= coreIn.nextPc;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreOut_r.statusUpdEn <= 1'b0;
    end else begin
      coreOut_r.statusUpdEn <= coreIn.statusUpdReq && !coreIn.swapInstr;
    end
  end

  // event status and interrupt line
  // pin edge logged as event
  always_comb begin
    evtIn             = '0;
    evtIn[EVT_EDGE]   = edgePulse;
    evtIn[EVT_WAKE]   = wakeNow;
    evtIn[EVT_VECTOR] = vectorNow;
  end

  eiwv_evt_unit u_evt (
    .core_clk    (core_clk),
    .rst         (rst),
    .evtIn       (evtIn),
    .statusClrWr (wrStatus),
    .maskWr      (wrMask),
    .wrData      (busIn.wdata[EVT_N-1:0]),
    .status      (evtStatus),
    .mask        (evtMask),
    .irqOut      (irqOut)
  );

  assign rdData   = rdData_r;
  assign coreOut  = coreOut_r;
  assign sleeping = sleeping_r;

endmodule : eiwv_top

// ===== src/eiwv_pkg.sv
// eiwv_pkg: constants, register map and carriers of the external interrupt,
// wake-up and vectoring block; shared by all design files of the block.
package eiwv_pkg;

  // register port and program counter widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 13;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMER_EDGE  = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS  = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK    = 8'h03;

  // irq_control_reg fields
  localparam int unsigned BIT_GLOBAL_IE = 7;
  localparam int unsigned BIT_EXT_IE    = 4;
  localparam int unsigned BIT_EXT_FLAG  = 1;
  localparam logic [DATA_W-1:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_CONTROL_RW  = 8'h92;

  // timer_edge_config fields
  localparam int unsigned BIT_EDGE_POL = 6;
  localparam logic [DATA_W-1:0] TIMER_EDGE_RST = 8'hFF;

  // event status / mask layout
  localparam int unsigned EVT_N       = 3;
  localparam int unsigned EVT_EDGE    = 0;
  localparam int unsigned EVT_WAKE    = 1;
  localparam int unsigned EVT_VECTOR  = 2;
  localparam logic [EVT_N-1:0] EVT_RST = 3'h0;

  // interrupt vector address
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_SLEEP,
    SEQ_WAKE_STEP
  } eiwv_seq_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } eiwv_bus_s;

  typedef struct packed {
    logic            sleepExec;
    logic            instrDone;
    logic            retFromIrq;
    logic            swapInstr;
    logic            statusUpdReq;
    logic [PC_W-1:0] nextPc;
  } eiwv_core_in_s;

  typedef struct packed {
    logic            wake;
    logic            pcLoad;
    logic [PC_W-1:0] pcLoadVal;
    logic            stackPush;
    logic [PC_W-1:0] stackData;
    logic            statusUpdEn;
  } eiwv_core_out_s;

endpackage : eiwv_pkg

// ===== src/eiwv_edge_catch.sv
// eiwv_edge_catch: clockless edge capture on the external interrupt pin,
// brought into the core clock domain as a one-cycle pulse.
// assumes pin and polarity are stable around polarity changes.
`timescale 1ns/1ns
module eiwv_edge_catch (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // pin side
  input  wire logic extIrqPin,
  input  wire logic edgePolaritySelect,
  // core side
  output logic      edgePulse
);
  import eiwv_pkg::*;

  logic                   edgeClk;
  logic                   edgeToggle_r;
  logic [SYNC_STAGES-1:0] syncChain_r;
  logic                   syncLast_r;
  logic                   edgePulse_r;

  assign edgeClk = extIrqPin ^ ~edgePolaritySelect;

  always_ff @(posedge edgeClk or posedge rst) begin
    if (rst) begin
      edgeToggle_r <= 1'b0;
    end else begin
      edgeToggle_r <= ~edgeToggle_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncChain_r <= '0;
      syncLast_r  <= 1'b0;
      edgePulse_r <= 1'b0;
    end else begin
      syncChain_r <= {syncChain_r[SYNC_STAGES-2:0], edgeToggle_r};
      syncLast_r  <= syncChain_r[SYNC_STAGES-1];
      edgePulse_r <= syncChain_r[SYNC_STAGES-1] ^ syncLast_r;
    end
  end

  assign edgePulse = edgePulse_r;

endmodule : eiwv_edge_catch

// ===== src/eiwv_evt_unit.sv
// eiwv_evt_unit: sticky event status with write-one-to-clear, mask, and a
// level interrupt output. assumes one-cycle event pulses.
`timescale 1ns/1ns
module eiwv_evt_unit (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // events
  input  wire logic [eiwv_pkg::EVT_N-1:0] evtIn,
  // software access
  input  wire logic                      statusClrWr,
  input  wire logic                      maskWr,
  input  wire logic [eiwv_pkg::EVT_N-1:0] wrData,
  output logic      [eiwv_pkg::EVT_N-1:0] status,
  output logic      [eiwv_pkg::EVT_N-1:0] mask,
  output logic                           irqOut
);
  import eiwv_pkg::*;

  logic [EVT_N-1:0] status_r;
  logic [EVT_N-1:0] mask_r;
  logic             irq_r;
  logic [EVT_N-1:0] status_nxt;
  logic [EVT_N-1:0] mask_nxt;

  // set wins over clear
  assign status_nxt = (status_r & ~({EVT_N{statusClrWr}} & wrData)) | evtIn;
  assign mask_nxt   = maskWr ? wrData : mask_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= EVT_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_r <= EVT_RST;
    end else if (maskWr) begin
      mask_r <= wrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irqOut = irq_r;

endmodule : eiwv_evt_unit

// ===== verif/eiwv_top_properties.sv
// eiwv_top_properties: port-level checks of the interrupt block.
// assumes it is bound into eiwv_top and sees only its ports.
`timescale 1ns/1ns
module eiwv_top_properties (
  // clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst,
  // observed ports
  input wire eiwv_pkg::eiwv_bus_s         busIn,
  input wire logic [eiwv_pkg::DATA_W-1:0] rdData,
  input wire logic                        extIrqPin,
  input wire eiwv_pkg::eiwv_core_in_s     coreIn,
  input wire eiwv_pkg::eiwv_core_out_s    coreOut,
  input wire logic                        sleeping,
  input wire logic                        irqOut
);
  import eiwv_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  vec_addr_a: assert property (coreOut.pcLoad |-> coreOut.pcLoadVal == 13'h0004)
    else $error("vector address wrong");
  push_only_a: assert property (coreOut.pcLoad == coreOut.stackPush)
    else $error("push and load apart");
  ret_addr_a: assert property (coreOut.pcLoad |-> coreOut.stackData == $past(coreIn.nextPc))
    else $error("wrong return address");
  vec_boundary_a: assert property (coreOut.pcLoad |-> $past(coreIn.instrDone))
    else $error("vector off a boundary");
  vec_once_a: assert property (coreOut.pcLoad |=> !coreOut.pcLoad)
    else $error("vector repeated");
  swap_keeps_a: assert property ($past(coreIn.swapInstr) |-> !coreOut.statusUpdEn)
    else $error("swap changed status");
  upd_pass_a: assert property ($past(coreIn.statusUpdReq) && !$past(coreIn.swapInstr) |-> coreOut.statusUpdEn)
    else $error("status update lost");
  wake_exit_a: assert property (coreOut.wake |-> $past(sleeping) && !sleeping)
    else $error("wake outside sleep");
  sleep_exit_a: assert property ($fell(sleeping) |-> coreOut.wake)
    else $error("sleep left without wake");
  sleep_novec_a: assert property (sleeping |-> !coreOut.pcLoad)
    else $error("vector while asleep");

  cover property (coreOut.pcLoad);
  cover property (coreOut.wake ##[1:20] coreOut.pcLoad);
  cover property (irqOut);
endmodule : eiwv_top_properties

bind eiwv_top eiwv_top_properties eiwv_top_properties_i (.core_clk, .rst, .busIn, .rdData, .extIrqPin,
  .coreIn, .coreOut, .sleeping, .irqOut);

// ===== verif/eiwv_core_model.sv
// eiwv_core_model: processor core and pin source beside the block.
// assumes the bench calls one task at a time.
`timescale 1ns/1ns
module eiwv_core_model (
  // clock
  input  wire logic                     core_clk,
  // block side
  input  wire eiwv_pkg::eiwv_core_out_s coreOut,
  output eiwv_pkg::eiwv_core_in_s       coreIn,
  output logic                          extIrqPin
);
  import eiwv_pkg::*;
  initial begin
    coreIn = '0;
    extIrqPin = 1'b0;
  end
  task automatic pin(input logic lvl);
    @(posedge core_clk);
    extIrqPin <= lvl;
  endtask : pin
  task automatic drive(input logic [4:0] ctl, input logic [PC_W-1:0] pc);
    @(posedge core_clk);
    coreIn <= {ctl, pc};
    @(posedge core_clk);
    coreIn <= '0;
    #1;
  endtask : drive
endmodule : eiwv_core_model

// ===== verif/eiwv_tb_top.sv
// eiwv_tb_top: self-checking bench of the interrupt block.
// assumes the core model and the bound checker.
`timescale 1ns/1ns
module eiwv_tb_top;
  import eiwv_pkg::*;
  localparam logic [4:0] SLP = 5'h10;
  localparam logic [4:0] DONE = 5'h08;
  localparam logic [4:0] RFI = 5'h04;
  localparam logic [4:0] SWP = 5'h02;
  localparam logic [4:0] UPD = 5'h01;
  // rows: write, address, data, expected read
  localparam logic [24:0] ROWS [13] = '{
    {1'b0, 8'h00, 8'h00, 8'h00}, {1'b0, 8'h01, 8'h00, 8'hFF}, {1'b0, 8'h02, 8'h00, 8'h00},
    {1'b0, 8'h03, 8'h00, 8'h00}, {1'b1, 8'h07, 8'h5A, 8'h00}, {1'b0, 8'h07, 8'h00, 8'h00},
    {1'b1, 8'h03, 8'h07, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h07}, {1'b1, 8'h00, 8'h6D, 8'h00},
    {1'b0, 8'h00, 8'h00, 8'h00}, {1'b1, 8'h00, 8'hFF, 8'h00}, {1'b0, 8'h00, 8'h00, 8'h92},
    {1'b1, 8'h00, 8'h00, 8'h00}};
  logic              core_clk;
  logic              rst;
  eiwv_bus_s         busIn;
  logic [DATA_W-1:0] rdData;
  logic              extIrqPin;
  eiwv_core_in_s     coreIn;
  eiwv_core_out_s    coreOut;
  logic              sleeping;
  logic              irqOut;
  logic [DATA_W-1:0] rdv;
  int                failCount = 0;
  int                testsRun = 0;
  int                cycles = 0;

  eiwv_top eiwv_top_i (.core_clk(core_clk), .rst(rst), .busIn(busIn), .rdData(rdData),
    .extIrqPin(extIrqPin), .coreIn(coreIn), .coreOut(coreOut), .sleeping(sleeping), .irqOut(irqOut));
  eiwv_core_model eiwv_core_model_i (.core_clk(core_clk), .coreOut(coreOut), .coreIn(coreIn),
    .extIrqPin(extIrqPin));

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  task automatic conclude;
    if (failCount == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busIn <= {a, d, w, !w};
    @(posedge core_clk);
    busIn.wr <= 1'b0;
    busIn.rd <= 1'b0;
    #1 rdv = rdData;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdv, e);
  endtask : rd

  task automatic waitWake;
    for (int k = 0; k < 12 && coreOut.wake !== 1'b1; k++) wt(1);
    chk(coreOut.wake, 1'b1);
  endtask : waitWake

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      conclude();
    end
  end

  initial begin
    busIn = '0;
    rst = 1'b0;
    // a reset edge after time zero also clears the pin-clocked toggle
    #1 rst = 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({sleeping, irqOut, coreOut.wake, coreOut.pcLoad, coreOut.pcLoadVal}, {4'h0, 13'h0004});
    chk({rdData, coreOut.stackPush, coreOut.stackData, coreOut.statusUpdEn}, 32'h0);
    for (int i = 0; i < 13; i++) begin
      bus(ROWS[i][24], ROWS[i][23:16], ROWS[i][15:8]);
      if (!ROWS[i][24]) chk(rdv, ROWS[i][7:0]);
    end
    for (int p = 1; p >= 0; p--) begin
      wr(OFS_TIMER_EDGE, {1'b1, p[0], 6'h3F});
      eiwv_core_model_i.pin(!p[0]);
      wt(6);
      wr(OFS_IRQ_CONTROL, 8'h00);
      wr(OFS_EVT_STATUS, 8'h07);
      eiwv_core_model_i.pin(p[0]);
      wt(6);
      rd(OFS_IRQ_CONTROL, 8'h02);
      rd(OFS_EVT_STATUS, 8'h01);
      chk(irqOut, 1'b1);
      wr(OFS_EVT_MASK, 8'h00);
      wt(2);
      chk(irqOut, 1'b0);
      wr(OFS_EVT_MASK, 8'h07);
      wr(OFS_EVT_STATUS, 8'h07);
      wt(2);
      chk(irqOut, 1'b0);
      wr(OFS_IRQ_CONTROL, 8'h00);
      eiwv_core_model_i.pin(!p[0]);
      wt(6);
      rd(OFS_IRQ_CONTROL, 8'h00);
    end
    wr(OFS_IRQ_CONTROL, 8'h12);
    eiwv_core_model_i.drive(DONE, 13'h0ABC);
    chk(coreOut.pcLoad, 1'b0);
    wr(OFS_IRQ_CONTROL, 8'h82);
    eiwv_core_model_i.drive(DONE, 13'h0ABC);
    chk(coreOut.pcLoad, 1'b0);
    wr(OFS_IRQ_CONTROL, 8'h92);
    eiwv_core_model_i.drive(DONE, 13'h1ABC);
    chk({coreOut.pcLoad, coreOut.stackPush, coreOut.pcLoadVal, coreOut.stackData}, {2'b11, 13'h0004, 13'h1ABC});
    rd(OFS_IRQ_CONTROL, 8'h12);
    bus(1'b0, OFS_EVT_STATUS, 8'h00);
    chk(rdv[EVT_VECTOR], 1'b1);
    wr(OFS_IRQ_CONTROL, 8'h10);
    eiwv_core_model_i.drive(RFI, 13'h0000);
    rd(OFS_IRQ_CONTROL, 8'h90);
    eiwv_core_model_i.drive(UPD, 13'h0000);
    chk(coreOut.statusUpdEn, 1'b1);
    eiwv_core_model_i.drive(UPD | SWP, 13'h0000);
    chk(coreOut.statusUpdEn, 1'b0);
    wr(OFS_IRQ_CONTROL, 8'h80);
    eiwv_core_model_i.drive(SLP, 13'h0000);
    chk(sleeping, 1'b1);
    wr(OFS_IRQ_CONTROL, 8'h90);
    eiwv_core_model_i.pin(1'b0);
    wt(8);
    chk(sleeping, 1'b1);
    rd(OFS_IRQ_CONTROL, 8'h92);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(sleeping, 1'b0);
    rd(OFS_IRQ_CONTROL, 8'h00);
    rd(OFS_TIMER_EDGE, 8'hFF);
    wr(OFS_IRQ_CONTROL, 8'h10);
    eiwv_core_model_i.drive(SLP, 13'h0000);
    eiwv_core_model_i.pin(1'b1);
    waitWake();
    chk(sleeping, 1'b0);
    eiwv_core_model_i.drive(DONE, 13'h0005);
    chk(coreOut.pcLoad, 1'b0);
    wr(OFS_IRQ_CONTROL, 8'h10);
    eiwv_core_model_i.pin(1'b0);
    wr(OFS_IRQ_CONTROL, 8'h90);
    eiwv_core_model_i.drive(SLP, 13'h0000);
    eiwv_core_model_i.pin(1'b1);
    waitWake();
    wt(3);
    chk(coreOut.pcLoad, 1'b0);
    eiwv_core_model_i.drive(DONE, 13'h0777);
    chk({coreOut.pcLoad, coreOut.stackData}, {1'b1, 13'h0777});
    wr(OFS_IRQ_CONTROL, 8'h90);
    eiwv_core_model_i.drive(SLP, 13'h0000);
    eiwv_core_model_i.pin(1'b0);
    eiwv_core_model_i.pin(1'b1);
    waitWake();
    wr(OFS_IRQ_CONTROL, 8'h90);
    eiwv_core_model_i.drive(DONE, 13'h0123);
    chk({coreOut.pcLoad, coreOut.stackData}, {1'b0, 13'h0777});
    conclude();
  end
endmodule : eiwv_tb_top
